// File: verilog/psu_seq_pkg.sv
// constants and types for the redundant supply power sequencer
// Function
// - main rail on only while on-request low
// - main off within 5 ms of release
// - main up 5 to 400 ms after request
// - outputs-good drops within 5 ms of release
// - outputs-good 100 to 500 ms after regulation
// - outputs-good low on undervoltage or dropout
// - current limit holds off outputs-good count
// - standby role sleeps on low load, bus high
// - wake bus low returns sleepers to sharing
// - role byte at D0h, byte transfers, checked
// - role codes 00h to 04h decoded
// - sleep delays 500/600/400 ms, wake order 1-2-3
// - standard role keeps others from sleeping
// - any fault resets role to 00h
// - sleep needs request, pool deasserted, role 2-4
// - sleeper wakes on bus low, keeps good, fans
// - sleeper hides faults, leaves on any fault
// - sleeper blinks green, or amber on warning
// - wake threshold on load share per position
// - active supply pulls wake-standby line on trouble
// - listed events pull the wake-standby line
// - request toggle or input loss clears latches
package psu_seq_pkg;
	localparam int CLK_CYC_PER_MS = 100_000;

	localparam int DEBOUNCE_MS    = 1;
	localparam int PSON_OFF_MAX_MS = 5;
	localparam int PSON_ON_MIN_MS = 5;
	localparam int PSON_ON_MAX_MS = 400;
	localparam int PSON_ON_MS     = 10;
	localparam int PWOK_MIN_MS    = 100;
	localparam int PWOK_MAX_MS    = 500;
	localparam int PWOK_MS        = 200;
	localparam int STBY1_MS       = 500;
	localparam int STBY2_MS       = 600;
	localparam int STBY3_MS       = 400;
	localparam int WAKE_PULSE_MS  = 10;
	localparam int BLINK_HALF_MS  = 500;

	localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_CYC_PER_MS;
	localparam int PSON_ON_CYC    = PSON_ON_MS * CLK_CYC_PER_MS;
	localparam int PWOK_CYC       = PWOK_MS * CLK_CYC_PER_MS;
	localparam int STBY1_CYC      = STBY1_MS * CLK_CYC_PER_MS;
	localparam int STBY2_CYC      = STBY2_MS * CLK_CYC_PER_MS;
	localparam int STBY3_CYC      = STBY3_MS * CLK_CYC_PER_MS;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * CLK_CYC_PER_MS;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_CYC_PER_MS;

	localparam logic [7:0] ROLE_CMD_CODE = 8'hd0;
	localparam logic [7:0] ROLE_RESET    = 8'h00;
	localparam logic [7:0] ROLE_STANDARD = 8'h00;
	localparam logic [7:0] ROLE_ACTIVE   = 8'h01;
	localparam logic [7:0] ROLE_STBY1    = 8'h02;
	localparam logic [7:0] ROLE_STBY2    = 8'h03;
	localparam logic [7:0] ROLE_STBY3    = 8'h04;

	localparam logic [7:0] LOAD_OFF_LVL  = 8'h40;
	localparam logic [7:0] LOAD_ON_LVL1  = 8'h60;
	localparam logic [7:0] LOAD_ON_LVL2  = 8'h68;
	localparam logic [7:0] LOAD_ON_LVL3  = 8'h70;

	localparam logic [7:0] PEC_POLY      = 8'h07;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ON_DELAY,
		ST_RUN,
		ST_STBY_WAIT,
		ST_SMART_STBY
	} seq_state_t;
endpackage

// File: verilog/pin_debouncer.sv
// two-flop synchroniser followed by a stability filter
`timescale 1ns/10ps
`default_nettype none
module pin_debouncer #(
	parameter int   STABLE_CYC = 100_000,
	parameter logic RESET_VAL  = 1'b1
) (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_level
);
	logic        sync1_reg;
	logic        sync2_reg;
	logic [31:0] stable_cnt_reg;

	if (STABLE_CYC < 1)
	begin : g_chk
		$error("pin_debouncer: STABLE_CYC must be at least 1");
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_reg <= RESET_VAL;
			sync2_reg <= RESET_VAL;
		end
		else
		begin
			sync1_reg <= i_async;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stable_cnt_reg <= 32'h0000_0000;
			o_level        <= RESET_VAL;
		end
		else if (sync2_reg == o_level)
			stable_cnt_reg <= 32'h0000_0000;
		else if (stable_cnt_reg >= 32'(STABLE_CYC - 1))
		begin
			stable_cnt_reg <= 32'h0000_0000;
			o_level        <= sync2_reg;
		end
		else
			stable_cnt_reg <= stable_cnt_reg + 32'h0000_0001;
	end
endmodule
`default_nettype wire

// File: verilog/redundant_psu_power_sequencer.sv
// on/off sequencing, outputs-good timing and smart standby control
`timescale 1ns/10ps
`default_nettype none
module redundant_psu_power_sequencer
	import psu_seq_pkg::*;
#(
	parameter int DEB_CYC   = DEBOUNCE_CYC,
	parameter int ON_CYC    = PSON_ON_CYC,
	parameter int GOOD_CYC  = PWOK_CYC,
	parameter int SLP1_CYC  = STBY1_CYC,
	parameter int SLP2_CYC  = STBY2_CYC,
	parameter int SLP3_CYC  = STBY3_CYC,
	parameter int WAKE_CYC  = WAKE_PULSE_CYC,
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_remote_on_input_n,
	input  wire logic       i_redundancy_pool_n,
	input  wire logic       i_wake_bus_in,
	output logic            o_wake_bus_out,
	output logic            o_wake_bus_oe,
	input  wire logic       i_wake_standby_n_in,
	output logic            o_wake_standby_n_out,
	output logic            o_wake_standby_n_oe,
	input  wire logic       i_rails_in_regulation,
	input  wire logic       i_current_limit,
	input  wire logic       i_input_dropout,
	input  wire logic       i_oc_warning,
	input  wire logic       i_oc_fault,
	input  wire logic       i_overvoltage_trip,
	input  wire logic       i_undervoltage_trip,
	input  wire logic       i_short_fault,
	input  wire logic       i_ot_fault,
	input  wire logic       i_fan_fault,
	input  wire logic       i_input_lost,
	input  wire logic       i_warning,
	input  wire logic [7:0] i_load_share,
	input  wire logic [6:0] i_smbus_addr,
	input  wire logic       i_cmd_valid,
	input  wire logic       i_cmd_is_read,
	input  wire logic [7:0] i_cmd_code,
	input  wire logic [7:0] i_cmd_data,
	input  wire logic [7:0] i_cmd_pec,
	output logic            o_cmd_done,
	output logic            o_cmd_ack,
	output logic [7:0]      o_rsp_data,
	output logic [7:0]      o_rsp_pec,
	output logic            o_main_enable,
	output logic            o_standby_rail_enable,
	output logic            o_outputs_good,
	output logic            o_fan_enable,
	output logic            o_led_green,
	output logic            o_led_amber,
	output logic            o_fault_report,
	output logic            o_smart_standby,
	output logic [7:0]      o_role
);
	if (DEB_CYC < 1 || ON_CYC < 1 || GOOD_CYC < 1 || SLP1_CYC < 1 || SLP2_CYC < 1 ||
		SLP3_CYC < 1 || WAKE_CYC < 1 || BLINK_CYC < 1)
	begin : g_chk
		$error("redundant_psu_power_sequencer: every count must be at least 1");
	end

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
		return c;
	endfunction

	function automatic logic is_sleeper(input logic [7:0] role);
		return (role == ROLE_STBY1) || (role == ROLE_STBY2) || (role == ROLE_STBY3);
	endfunction

	function automatic logic [31:0] sleep_delay(input logic [7:0] role);
		if (role == ROLE_STBY1)
			return 32'(SLP1_CYC);
		else if (role == ROLE_STBY2)
			return 32'(SLP2_CYC);
		else
			return 32'(SLP3_CYC);
	endfunction

	function automatic logic [7:0] wake_level(input logic [7:0] role);
		if (role == ROLE_STBY1)
			return LOAD_ON_LVL1;
		else if (role == ROLE_STBY2)
			return LOAD_ON_LVL2;
		else
			return LOAD_ON_LVL3;
	endfunction

	logic        rst_sync1_reg;
	logic        rst_n;
	logic        pson_n_db;
	logic        pool_n_db;
	logic        wake_bus_db;
	logic        wake_stby_n_db;
	logic        on_req;
	logic        on_req_d_reg;
	logic        on_fall;
	logic        shut_latch_reg;
	logic        fault_any;
	logic        main_allowed;
	logic        smart_ok;
	logic        load_low;
	logic        load_high;
	logic        write_ok;
	logic        write_pec_ok;
	logic [7:0]  write_pec;
	logic [7:0]  role_reg;
	seq_state_t  state_reg;
	seq_state_t  state_next;
	logic [31:0] seq_cnt_reg;
	logic [31:0] seq_cnt_next;
	logic [31:0] good_cnt_reg;
	logic [31:0] wake_cnt_reg;
	logic [31:0] blink_cnt_reg;
	logic        blink_reg;
	logic        wake_level_trig;

	// reset release through two flops
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_sync1_reg <= 1'b0;
			rst_n         <= 1'b0;
		end
		else
		begin
			rst_sync1_reg <= 1'b1;
			rst_n         <= rst_sync1_reg;
		end
	end

	pin_debouncer #(.STABLE_CYC(DEB_CYC), .RESET_VAL(1'b1)) u_pson_db (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.i_async (i_remote_on_input_n),
		.o_level (pson_n_db)
	);

	pin_debouncer #(.STABLE_CYC(DEB_CYC), .RESET_VAL(1'b1)) u_pool_db (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.i_async (i_redundancy_pool_n),
		.o_level (pool_n_db)
	);

	pin_debouncer #(.STABLE_CYC(DEB_CYC), .RESET_VAL(1'b1)) u_wake_bus_db (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.i_async (i_wake_bus_in),
		.o_level (wake_bus_db)
	);

	pin_debouncer #(.STABLE_CYC(DEB_CYC), .RESET_VAL(1'b1)) u_wake_stby_db (
		.i_clock (i_clock),
		.i_rst_n (rst_n),
		.i_async (i_wake_standby_n_in),
		.o_level (wake_stby_n_db)
	);

	assign on_req    = ~pson_n_db;
	assign on_fall   = on_req_d_reg & ~on_req;
	assign fault_any = i_oc_fault | i_overvoltage_trip | i_short_fault | i_ot_fault | i_fan_fault | i_input_lost;
	assign main_allowed = on_req & ~shut_latch_reg & ~i_ot_fault & ~i_input_lost;
	// sleep is allowed only with request, free pool, sleeper role, quiet bus
	assign smart_ok = on_req & pool_n_db & is_sleeper(role_reg) & wake_bus_db & wake_stby_n_db &
		~fault_any;
	assign load_low  = i_load_share < LOAD_OFF_LVL;
	assign load_high = i_load_share > wake_level(role_reg);

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			on_req_d_reg <= 1'b0;
		else
			on_req_d_reg <= on_req;
	end

	// latched shutdowns; a new trip wins over the clear
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			shut_latch_reg <= 1'b0;
		else if (i_oc_fault | i_overvoltage_trip | i_short_fault)
			shut_latch_reg <= 1'b1;
		else if (on_fall | i_input_lost)
			shut_latch_reg <= 1'b0;
	end

	always_comb
	begin
		state_next   = state_reg;
		seq_cnt_next = seq_cnt_reg + 32'h0000_0001;
		case (state_reg)
			ST_OFF:
			begin
				seq_cnt_next = 32'h0000_0000;
				if (main_allowed)
					state_next = ST_ON_DELAY;
			end
			ST_ON_DELAY:
			begin
				if (!main_allowed)
					state_next = ST_OFF;
				else if (seq_cnt_reg >= 32'(ON_CYC - 1))
				begin
					state_next   = ST_RUN;
					seq_cnt_next = 32'h0000_0000;
				end
			end
			ST_RUN:
			begin
				seq_cnt_next = 32'h0000_0000;
				if (!main_allowed)
					state_next = ST_OFF;
				else if (smart_ok && load_low)
					state_next = ST_STBY_WAIT;
			end
			ST_STBY_WAIT:
			begin
				if (!main_allowed)
					state_next = ST_OFF;
				else if (!(smart_ok && load_low))
				begin
					state_next   = ST_RUN;
					seq_cnt_next = 32'h0000_0000;
				end
				else if (seq_cnt_reg >= sleep_delay(role_reg) - 32'h0000_0001)
				begin
					state_next   = ST_SMART_STBY;
					seq_cnt_next = 32'h0000_0000;
				end
			end
			ST_SMART_STBY:
			begin
				seq_cnt_next = 32'h0000_0000;
				if (!main_allowed)
					state_next = ST_OFF;
				else if (!smart_ok || load_high)
					state_next = ST_RUN;
			end
			default:
			begin
				state_next   = ST_OFF;
				seq_cnt_next = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= ST_OFF;
			seq_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			state_reg   <= state_next;
			seq_cnt_reg <= seq_cnt_next;
		end
	end

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_main_enable   <= 1'b0;
			o_smart_standby <= 1'b0;
			o_fan_enable    <= 1'b0;
			o_fault_report  <= 1'b0;
		end
		else
		begin
			o_main_enable   <= (state_next == ST_RUN) || (state_next == ST_STBY_WAIT);
			o_smart_standby <= state_next == ST_SMART_STBY;
			o_fan_enable    <= state_next != ST_OFF;
			o_fault_report  <= fault_any && (state_reg != ST_SMART_STBY);
		end
	end

	// outputs-good delay; current limit holds the count at its start
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_outputs_good <= 1'b0;
			good_cnt_reg   <= 32'h0000_0000;
		end
		else if (!on_req || i_input_dropout || !main_allowed)
		begin
			o_outputs_good <= 1'b0;
			good_cnt_reg   <= 32'h0000_0000;
		end
		else if (state_reg == ST_SMART_STBY)
			o_outputs_good <= o_outputs_good;
		else if (!i_rails_in_regulation || !o_main_enable)
		begin
			o_outputs_good <= 1'b0;
			good_cnt_reg   <= 32'h0000_0000;
		end
		else if (!o_outputs_good)
		begin
			if (good_cnt_reg == 32'h0000_0000 && i_current_limit)
				good_cnt_reg <= 32'h0000_0000;
			else if (good_cnt_reg >= 32'(GOOD_CYC - 1))
				o_outputs_good <= 1'b1;
			else
				good_cnt_reg <= good_cnt_reg + 32'h0000_0001;
		end
	end

	assign write_pec    = crc8(crc8(crc8(8'h00, {i_smbus_addr, 1'b0}), i_cmd_code), i_cmd_data);
	assign write_pec_ok = write_pec == i_cmd_pec;
	assign write_ok     = i_cmd_valid && !i_cmd_is_read && (i_cmd_code == ROLE_CMD_CODE) &&
		write_pec_ok && (i_cmd_data <= ROLE_STBY3);

	// role byte; a fault in the same cycle as a write wins
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			role_reg <= ROLE_RESET;
		else if (fault_any)
			role_reg <= ROLE_RESET;
		else if (write_ok)
			role_reg <= i_cmd_data;
	end

	assign o_role = role_reg;

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_cmd_done <= 1'b0;
			o_cmd_ack  <= 1'b0;
			o_rsp_data <= 8'h00;
			o_rsp_pec  <= 8'h00;
		end
		else
		begin
			o_cmd_done <= i_cmd_valid;
			if (i_cmd_valid && i_cmd_is_read)
			begin
				o_cmd_ack  <= i_cmd_code == ROLE_CMD_CODE;
				o_rsp_data <= (i_cmd_code == ROLE_CMD_CODE) ? role_reg : 8'h00;
				o_rsp_pec  <= crc8(crc8(crc8(crc8(8'h00, {i_smbus_addr, 1'b0}), i_cmd_code),
					{i_smbus_addr, 1'b1}), (i_cmd_code == ROLE_CMD_CODE) ? role_reg : 8'h00);
			end
			else if (i_cmd_valid)
				o_cmd_ack <= write_ok;
		end
	end

	// wake-standby line: level troubles while active, stretched events
	assign wake_level_trig = o_main_enable && (i_oc_warning || i_oc_fault || i_overvoltage_trip ||
		i_undervoltage_trip || i_ot_fault || i_fan_fault || i_input_lost);

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			wake_cnt_reg <= 32'h0000_0000;
		else if ((write_ok && i_cmd_data == ROLE_STANDARD) || on_fall || (o_main_enable && !main_allowed))
			wake_cnt_reg <= 32'(WAKE_CYC);
		else if (wake_cnt_reg != 32'h0000_0000)
			wake_cnt_reg <= wake_cnt_reg - 32'h0000_0001;
	end

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_wake_standby_n_oe <= 1'b0;
			o_wake_bus_oe       <= 1'b0;
		end
		else
		begin
			o_wake_standby_n_oe <= wake_level_trig || (wake_cnt_reg != 32'h0000_0000);
			// standard role holds the wake bus low so nobody sleeps
			o_wake_bus_oe <= (role_reg == ROLE_STANDARD) && o_main_enable;
		end
	end

	assign o_wake_standby_n_out  = 1'b0;
	assign o_wake_bus_out        = 1'b0;
	assign o_standby_rail_enable = 1'b1;

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			blink_cnt_reg <= 32'h0000_0000;
			blink_reg     <= 1'b0;
		end
		else if (blink_cnt_reg >= 32'(BLINK_CYC - 1))
		begin
			blink_cnt_reg <= 32'h0000_0000;
			blink_reg     <= ~blink_reg;
		end
		else
			blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_led_green <= 1'b0;
			o_led_amber <= 1'b0;
		end
		else if (fault_any || shut_latch_reg)
		begin
			o_led_green <= 1'b0;
			o_led_amber <= 1'b1;
		end
		else if (i_warning)
		begin
			o_led_green <= 1'b0;
			o_led_amber <= blink_reg;
		end
		else if (state_reg == ST_SMART_STBY || state_reg == ST_OFF)
		begin
			o_led_green <= blink_reg;
			o_led_amber <= 1'b0;
		end
		else
		begin
			o_led_green <= o_outputs_good;
			o_led_amber <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verification/psu_seq_chk.sv
// port assertions for the redundant supply power sequencer
`timescale 1ns/10ps
`default_nettype none
module psu_seq_chk #(
	parameter int DEB_CYC  = 4,
	parameter int ON_CYC   = 50,
	parameter int GOOD_CYC = 100
) (
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic       i_remote_on_input_n,
	input wire logic       i_redundancy_pool_n,
	input wire logic       i_rails_in_regulation,
	input wire logic       i_current_limit,
	input wire logic       i_input_dropout,
	input wire logic       i_oc_warning,
	input wire logic       i_oc_fault,
	input wire logic       i_ot_fault,
	input wire logic       i_fan_fault,
	input wire logic       i_cmd_valid,
	input wire logic [7:0] i_cmd_code,
	input wire logic       o_cmd_done,
	input wire logic       o_cmd_ack,
	input wire logic       o_main_enable,
	input wire logic       o_outputs_good,
	input wire logic       o_fan_enable,
	input wire logic       o_fault_report,
	input wire logic       o_smart_standby,
	input wire logic [7:0] o_role,
	input wire logic       o_wake_bus_oe,
	input wire logic       o_wake_standby_n_oe
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	logic [4:0]  hi_cnt;
	int unsigned lo_cnt;
	int unsigned gd_cnt;
	logic        cl_free;
	// request high time, request low time, time in regulation, count start seen
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			hi_cnt <= 5'h00;
			lo_cnt <= 0;
			gd_cnt <= 0;
			cl_free <= 1'b0;
		end
		else
		begin
			hi_cnt <= !i_remote_on_input_n ? 5'h00 : (hi_cnt == 5'h10 ? hi_cnt : hi_cnt + 5'h01);
			lo_cnt <= i_remote_on_input_n ? 0 : lo_cnt + 1;
			gd_cnt <= (o_main_enable && i_rails_in_regulation && !i_current_limit && !i_input_dropout) ? gd_cnt + 1 : 0;
			// good count may only start in a cycle free of current limit
			if (!o_smart_standby && (!o_main_enable || !i_rails_in_regulation || i_input_dropout))
				cl_free <= 1'b0;
			else if (!i_current_limit)
				cl_free <= 1'b1;
		end
	end
	property p_off_main;
		hi_cnt == 5'h10 |-> !o_main_enable;
	endproperty
	a_off_main: assert property (p_off_main) else $error("main on after release");
	property p_off_good;
		hi_cnt == 5'h10 |-> !o_outputs_good;
	endproperty
	a_off_good: assert property (p_off_good) else $error("good high after release");
	property p_on_min;
		$rose(o_main_enable) |-> lo_cnt >= ON_CYC;
	endproperty
	a_on_min: assert property (p_on_min) else $error("main up too early");
	property p_good_delay;
		$rose(o_outputs_good) |-> gd_cnt >= GOOD_CYC - 2;
	endproperty
	a_good_delay: assert property (p_good_delay) else $error("good too early");
	property p_good_low;
		(!i_rails_in_regulation || i_input_dropout) && !o_smart_standby ##1 !o_smart_standby |-> !o_outputs_good;
	endproperty
	a_good_low: assert property (p_good_low) else $error("good kept out of regulation");
	property p_cl_hold;
		$rose(o_outputs_good) |-> cl_free;
	endproperty
	a_cl_hold: assert property (p_cl_hold) else $error("good rose in current limit");
	property p_role_fault;
		i_oc_fault || i_ot_fault || i_fan_fault |=> o_role == 8'h00;
	endproperty
	a_role_fault: assert property (p_role_fault) else $error("role kept on fault");
	property p_role_range;
		o_role <= 8'h04;
	endproperty
	a_role_range: assert property (p_role_range) else $error("role out of range");
	property p_nack;
		i_cmd_valid && i_cmd_code != 8'hd0 |=> o_cmd_done && !o_cmd_ack;
	endproperty
	a_nack: assert property (p_nack) else $error("other code acknowledged");
	property p_stby_hold;
		o_smart_standby |-> o_fan_enable && !o_fault_report && !o_main_enable;
	endproperty
	a_stby_hold: assert property (p_stby_hold) else $error("standby outputs wrong");
	property p_stby_entry;
		$rose(o_smart_standby) |-> $past(o_role) >= 8'h02 && $past(i_redundancy_pool_n) && !$past(i_remote_on_input_n);
	endproperty
	a_stby_entry: assert property (p_stby_entry) else $error("standby without its conditions");
	property p_wake_std;
		o_main_enable && (i_oc_warning || i_fan_fault) |=> o_wake_standby_n_oe;
	endproperty
	a_wake_std: assert property (p_wake_std) else $error("wake line not pulled");
	property p_wake_bus;
		o_role == 8'h00 && o_main_enable ##1 o_role == 8'h00 && o_main_enable |-> o_wake_bus_oe;
	endproperty
	a_wake_bus: assert property (p_wake_bus) else $error("wake bus not held");
	c_stby: cover property ($rose(o_smart_standby));
	c_good: cover property ($rose(o_outputs_good));
	c_wake: cover property ($rose(o_wake_standby_n_oe));
	c_nack: cover property (i_cmd_valid && i_cmd_code != 8'hd0);
endmodule
bind redundant_psu_power_sequencer psu_seq_chk #(.DEB_CYC(DEB_CYC), .ON_CYC(ON_CYC), .GOOD_CYC(GOOD_CYC)) u_chk (.*);
`default_nettype wire

// File: verification/psu_peer_model.sv
// parallel supplies sharing the pulled-up wake bus and wake-standby wires
`timescale 1ns/10ps
`default_nettype none
module psu_peer_model (
	input  wire logic i_dut_bus_oe,
	input  wire logic i_dut_stby_oe,
	input  wire logic i_peer_bus_pull,
	input  wire logic i_peer_stby_pull,
	output logic      o_bus_level,
	output logic      o_stby_level
);
	// wired-and, the pull-up wins only when nobody pulls low
	assign o_bus_level  = !(i_dut_bus_oe || i_peer_bus_pull);
	assign o_stby_level = !(i_dut_stby_oe || i_peer_stby_pull);
endmodule
`default_nettype wire

// File: verification/redundant_psu_power_sequencer_tb_top.sv
// self-checking bench for the redundant supply power sequencer
`timescale 1ns/10ps
`default_nettype none
module redundant_psu_power_sequencer_tb_top
	import psu_seq_pkg::*;
;
	localparam int         DEB    = 4;
	localparam int         ONC    = 50;
	localparam int         GDC    = 100;
	localparam int         SLP[3] = '{50, 60, 40};
	localparam logic [7:0] LVL[3] = '{LOAD_ON_LVL1, LOAD_ON_LVL2, LOAD_ON_LVL3};
	logic       i_clock, i_resetn, i_remote_on_input_n, i_redundancy_pool_n, i_wake_bus_in, i_wake_standby_n_in;
	logic       i_rails_in_regulation, i_current_limit, i_input_dropout, i_cmd_valid, i_cmd_is_read, g;
	logic       bus_pull, stby_pull, o_wake_bus_out, o_wake_bus_oe, o_wake_standby_n_out, o_wake_standby_n_oe;
	logic       o_cmd_done, o_cmd_ack, o_main_enable, o_standby_rail_enable, o_outputs_good, o_fan_enable;
	logic       o_led_green, o_led_amber, o_fault_report, o_smart_standby;
	wire        i_oc_fault, i_overvoltage_trip, i_short_fault, i_input_lost, i_ot_fault, i_fan_fault;
	wire        i_undervoltage_trip, i_oc_warning, i_warning;
	logic [8:0] fv;
	logic [7:0] i_load_share, i_cmd_code, i_cmd_data, i_cmd_pec, o_rsp_data, o_rsp_pec, o_role, exp_pec;
	logic [6:0] i_smbus_addr;
	int         err_total, n_tests, n, r;
	assign {i_warning, i_oc_warning, i_undervoltage_trip, i_fan_fault, i_ot_fault, i_input_lost, i_short_fault,
		i_overvoltage_trip, i_oc_fault} = fv;
	redundant_psu_power_sequencer #(.DEB_CYC(DEB), .ON_CYC(ONC), .GOOD_CYC(GDC), .SLP1_CYC(SLP[0]),
		.SLP2_CYC(SLP[1]), .SLP3_CYC(SLP[2]), .WAKE_CYC(20), .BLINK_CYC(30)) uut (.*);
	psu_peer_model peer (.i_dut_bus_oe(o_wake_bus_oe), .i_dut_stby_oe(o_wake_standby_n_oe),
		.i_peer_bus_pull(bus_pull), .i_peer_stby_pull(stby_pull), .o_bus_level(i_wake_bus_in),
		.o_stby_level(i_wake_standby_n_in));
	always #5 i_clock = !i_clock;
	task automatic tick(input int k = 1);
		repeat (k) @(posedge i_clock);
		#1;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
		return x;
	endfunction
	// one decoded transfer, answer visible on return
	task automatic cmd(input logic rd, input logic [7:0] code, input logic [7:0] data, input logic bad);
		tick();
		i_cmd_valid = 1'b1;
		i_cmd_is_read = rd;
		i_cmd_code = code;
		i_cmd_data = data;
		i_cmd_pec = crc(crc(crc(8'h00, {i_smbus_addr, 1'b0}), code), data) ^ {7'h00, bad};
		tick();
		i_cmd_valid = 1'b0;
	endtask
	task automatic test_done();
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		{i_clock, i_resetn, i_rails_in_regulation, i_current_limit, i_input_dropout, i_cmd_valid} = '0;
		{i_cmd_is_read, bus_pull, stby_pull, fv, i_load_share, i_cmd_code, i_cmd_data, i_cmd_pec} = '0;
		{i_remote_on_input_n, i_redundancy_pool_n} = 2'b11;
		i_smbus_addr = 7'h2c;
		err_total = 0;
		n_tests = 0;
		tick(10);
		i_resetn = 1'b1;
		tick(3);
		chk(o_role === ROLE_RESET && o_main_enable === 1'b0 && o_outputs_good === 1'b0, "reset");
		chk(o_standby_rail_enable === 1'b1 && o_wake_bus_out === 1'b0 && o_wake_standby_n_out === 1'b0, "rails");
		for (r = 0; r < 5; r++)
		begin
			cmd(0, ROLE_CMD_CODE, r[7:0], 0);
			chk(o_cmd_done === 1'b1 && o_cmd_ack === 1'b1 && o_role === r[7:0], "role write");
			cmd(1, ROLE_CMD_CODE, 8'h00, 0);
			exp_pec = crc(crc(crc(crc(8'h00, {i_smbus_addr, 1'b0}), ROLE_CMD_CODE), {i_smbus_addr, 1'b1}), r[7:0]);
			chk(o_cmd_ack === 1'b1 && o_rsp_data === r[7:0] && o_rsp_pec === exp_pec, "role read");
		end
		cmd(0, ROLE_CMD_CODE, 8'h05, 0);
		chk(o_cmd_ack === 1'b0 && o_role === ROLE_STBY3, "bad value taken");
		cmd(0, ROLE_CMD_CODE, 8'h01, 1);
		chk(o_cmd_ack === 1'b0 && o_role === ROLE_STBY3, "bad check taken");
		cmd(0, 8'hd1, 8'h01, 0);
		cmd(0, ROLE_CMD_CODE, ROLE_STANDARD, 0);
		tick();
		chk(o_wake_standby_n_oe === 1'b1, "no wake on 00h");
		i_remote_on_input_n = 1'b0;
		i_current_limit = 1'b1;
		for (n = 0; n < 200 && o_main_enable !== 1'b1; n++) tick();
		chk(n >= ONC && n <= ONC + DEB + 10, "on delay");
		i_rails_in_regulation = 1'b1;
		tick(30);
		i_current_limit = 1'b0;
		for (n = 0; n < 300 && o_outputs_good !== 1'b1; n++) tick();
		chk(n >= GDC - 2 && n <= GDC + 5, "good delay");
		i_input_dropout = 1'b1;
		tick(2);
		chk(o_outputs_good === 1'b0, "good at dropout");
		i_input_dropout = 1'b0;
		for (n = 0; n < 300 && o_outputs_good !== 1'b1; n++) tick();
		i_load_share = 8'hff;
		for (r = 0; r < 3; r++)
		begin
			cmd(0, ROLE_CMD_CODE, ROLE_STBY1 + r[7:0], 0);
			i_load_share = 8'h20;
			for (n = 0; n < 200 && o_smart_standby !== 1'b1; n++) tick();
			chk(n >= SLP[r] && n <= SLP[r] + DEB + 12, "sleep delay");
			chk(o_outputs_good === 1'b1, "good in standby");
			tick();
			g = o_led_green;
			tick(30);
			chk(o_led_green === !g && o_led_amber === 1'b0, "standby blink");
			i_load_share = LVL[r];
			tick(3);
			chk(o_smart_standby === 1'b1, "woke below threshold");
			i_load_share = LVL[r] + 8'h01;
			tick(3);
			chk(o_smart_standby === 1'b0 && o_main_enable === 1'b1, "no wake on load");
		end
		i_load_share = 8'h20;
		for (r = 0; r < 2; r++)
		begin
			for (n = 0; n < 200 && o_smart_standby !== 1'b1; n++) tick();
			{bus_pull, stby_pull} = r ? 2'b01 : 2'b10;
			for (n = 0; n < 50 && o_main_enable !== 1'b1; n++) tick();
			chk(n <= DEB + 8, "wire wake");
			{bus_pull, stby_pull} = 2'b00;
		end
		i_redundancy_pool_n = 1'b0;
		for (r = 0; r < 9; r++)
		begin
			cmd(0, ROLE_CMD_CODE, ROLE_STBY3, 0);
			fv = 9'h001 << r;
			tick(3);
			chk(o_wake_standby_n_oe === (r < 8) && (o_role === ROLE_RESET) === (r < 6), "fault event");
			chk(o_main_enable === (r >= 5) && o_fault_report === (r < 6), "fault stop");
			fv = '0;
			tick(ONC + DEB + 15);
			chk(o_main_enable === (r >= 3), "latch");
			i_remote_on_input_n = 1'b1;
			tick(DEB + 8);
			i_remote_on_input_n = 1'b0;
			for (n = 0; n < 200 && o_main_enable !== 1'b1; n++) tick();
			chk(n <= ONC + DEB + 10, "restart");
		end
		chk(o_smart_standby === 1'b0, "slept with pool asserted");
		for (n = 0; n < 300 && o_outputs_good !== 1'b1; n++) tick();
		i_remote_on_input_n = 1'b1;
		tick(DEB + 8);
		chk(o_main_enable === 1'b0 && o_outputs_good === 1'b0, "release");
		chk(o_wake_standby_n_oe === 1'b1, "release wake");
		test_done();
	end
	initial
	begin
		#200000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
